// [dmem_defines.vh]
/*
  Constants for the data memory address decoder: register-file
  offsets, pointer fields, bank layout and variant codes.
  Assumes it is included by its bare name from the decoder source.
*/
`ifndef DMEM_DEFINES_VH
`define DMEM_DEFINES_VH

// Register-file offsets (6-bit location)
`define ADDR_INDIRECT   6'h00
`define ADDR_TIMER      6'h01
`define ADDR_PCL        6'h02
`define ADDR_FLAGS      6'h03
`define ADDR_POINTER    6'h04
`define ADDR_PORT_A     6'h05
`define ADDR_PORT_B     6'h06
`define ADDR_PORT_C     6'h07
`define ADDR_POWER      6'h08
`define ADDR_WAKE       6'h09
`define ADDR_PC_HIGH_BUFFER     6'h0a
`define ADDR_PULL_DOWN  6'h0b
`define ADDR_OPEN_DRAIN 6'h0c
`define ADDR_PULL_HIGH  6'h0d
`define ADDR_INT_EN     6'h0e
`define ADDR_INT_FLAG   6'h0f
`define ADDR_GP_FIRST   6'h10
`define ADDR_BANKED     6'h30

// Pointer fields
`define PTR_LOC_MSB     5
`define PTR_BANK_MSB    7
`define PTR_BANK_LSB    6

// Fixed read values
`define READ_ZERO       8'h00
`define BANK_ONES       2'h3

// Storage layout: index = location below 30h, 30h + 16*bank above;
// bank 3 window ends at 6Fh, so the array spans 112 words
`define STORE_AW        7
`define STORE_DEPTH     112
`define SHARED_WORDS    7'h30
`define BANK_SPAN       7'h10

// Variant codes
`define VAR_512_SMALL   2'h0
`define VAR_512_LARGE   2'h1
`define VAR_1K          2'h2
`define VAR_2K          2'h3

// Implemented bit masks
`define MASK_PORT_A     8'h0f
`define MASK_POWER      8'hf0
`define MASK_INT_EN     8'h8f
`define MASK_INT_FLAG   8'h07
`define MASK_PCH_1      8'h01
`define MASK_PCH_2      8'h03
`define MASK_PCH_3      8'h07

`endif

// [dmem_store.v]
/*
  Single-port storage for the general-purpose locations. Write is
  synchronous; read data come out of a register one cycle later.
  Assumes the caller presents an in-range word address.
*/
`timescale 1ns/10ps
`default_nettype none
module dmem_store #(
  parameter AW    = 7,
  parameter DEPTH = 96
) (
  input  wire          i_clk,   // Core clock
  input  wire          i_we,    // Write strobe
  input  wire [AW-1:0] i_addr,  // Word address
  input  wire [7:0]    i_wdata, // Write data
  output reg  [7:0]    o_rdata  // Registered read data
);
  reg [7:0] mem [0:DEPTH-1];

  // Write; registered read returns the old word
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule // dmem_store
`default_nettype wire

// [dmem_decode.v]
/*
  Data memory address decoder and special-function register file of
  a small 8-bit microcontroller core. Resolves direct and indirect
  accesses, bank selection, mirroring and unimplemented bits.
  Assumes the CPU datapath holds a request for one cycle, takes read
  data on O_RD_VALID two cycles later, and feeds the peripheral-owned
  values (timer, PC low, flags) in on its own clock; port pins are asynchronous.
*/
// Summary of operation
// - Indirect location has no storage; accesses go to pointer target.
// - Indirect read while pointer selects location zero returns 00h.
// - Indirect write while pointer selects location zero stores nothing.
// - Pointer bits 5-0 select one of 64 locations 00h-3Fh.
// - Four-bank variant: pointer bits 7-6 pick banks 0 to 3.
// - Four-bank variant: up to 2Fh shared; 30h-3Fh distinct per bank.
// - Unimplemented register bits ignore writes and read zero.
// - Single-bank variants: bank bits unused and read as one.
// - PC high buffer holds 1, 2 or 3 bits by memory size.
// - Single-bank: 00h-0Fh special registers, 10h-3Fh general storage.
// - Without third port, location 07h is ordinary storage.
`timescale 1ns/10ps
`default_nettype none
`include "dmem_defines.vh"
module dmem_decode #(
  parameter [1:0] VARIANT   = `VAR_2K,  // Memory-size variant
  parameter       HAS_PORT_C_DATA = 1         // Third I/O port present
) (
  input  wire       I_SYS_CLK,     // Core clock, 100 MHz
  input  wire       I_RST_B,       // Async reset, active low
  input  wire       I_RD,          // Read request, one cycle
  input  wire       I_WR,          // Write request, one cycle
  input  wire       I_INDIRECT,    // Access through indirect port
  input  wire [5:0] I_ADDR,        // Direct operand address
  input  wire [7:0] I_WDATA,       // Write data
  input  wire [7:0] I_TIMER,       // Timer count value
  input  wire [7:0] I_PCL,         // Program counter low byte
  input  wire [7:0] I_FLAGS,       // Processor flags value
  input  wire [7:0] I_PORT_A_PINS, // Port A pin levels
  input  wire [7:0] I_PORT_B_PINS, // Port B pin levels
  input  wire [7:0] I_PORT_C_PINS, // Port C pin levels
  output reg  [7:0] O_RDATA,       // Read data
  output reg        O_RD_VALID,    // Read data valid pulse
  output reg  [5:0] O_PERIPH_SEL,  // Peripheral write location
  output reg  [7:0] O_PERIPH_DATA, // Peripheral write data
  output reg        O_PERIPH_WR,   // Peripheral write pulse
  output reg  [7:0] O_POINTER,     // Indirect pointer as read
  output reg  [7:0] O_PORT_A,      // Port A data latch
  output reg  [7:0] O_PORT_B,      // Port B data latch
  output reg  [7:0] O_PORT_C,      // Port C data latch
  output reg  [7:0] O_POWER,       // Power control
  output reg  [7:0] O_WAKE,        // Wake change control
  output reg  [7:0] O_PC_HIGH_BUFFER,      // PC high buffer
  output reg  [7:0] O_PULL_DOWN,   // Pull-down control
  output reg  [7:0] O_OPEN_DRAIN,  // Open-drain control
  output reg  [7:0] O_PULL_HIGH,   // Pull-high control
  output reg  [7:0] O_INT_EN,      // Interrupt enables
  output reg  [7:0] O_INT_FLAG     // Interrupt flags
);
  localparam FOUR_BANK = (VARIANT == `VAR_2K);

  // Implemented bits of the PC high buffer per variant
  function [7:0] pch_mask;
    input [1:0] v;
    begin
      case (v)
        `VAR_1K: pch_mask = `MASK_PCH_2;
        `VAR_2K: pch_mask = `MASK_PCH_3;
        default: pch_mask = `MASK_PCH_1;
      endcase
    end
  endfunction

  // True where a location is storage rather than a special register
  function is_gp;
    input [5:0] loc;
    begin
      is_gp = (loc >= `ADDR_GP_FIRST) ||
              ((loc == `ADDR_PORT_C) && (HAS_PORT_C_DATA == 0));
    end
  endfunction

  // Pointer holds a 6-bit location and two bank bits
  reg  [5:0] ptr_loc;
  reg  [1:0] ptr_bank;
  wire [1:0] bank_rd = FOUR_BANK ? ptr_bank : `BANK_ONES;
  wire [7:0] ptr_rd  = {bank_rd, ptr_loc};

  // Effective location: operand, or pointer low six bits
  wire [5:0] eff_loc  = I_INDIRECT ? ptr_loc : I_ADDR;
  wire [1:0] eff_bank = FOUR_BANK ? ptr_bank : 2'h0;
  wire       self_ref = (eff_loc == `ADDR_INDIRECT);
  wire       gp_hit   = is_gp(eff_loc);

  // Storage index: shared below 30h, bank window above
  reg [6:0] store_addr;
  always @* begin
    store_addr = {1'b0, eff_loc};
    if (FOUR_BANK && (eff_loc >= `ADDR_BANKED) && (eff_bank != 2'h0)) begin
      store_addr = `SHARED_WORDS +
                   (`BANK_SPAN * {5'h0, eff_bank}) +
                   {1'b0, eff_loc} - {1'b0, `ADDR_BANKED};
    end
  end

  wire       store_we = I_WR && gp_hit;  // self never reaches here
  wire [7:0] store_q;

  dmem_store #(
    .AW    (`STORE_AW),
    .DEPTH (`STORE_DEPTH)
  ) u_store (
    .i_clk   (I_SYS_CLK),
    .i_we    (store_we),
    .i_addr  (store_addr),
    .i_wdata (I_WDATA),
    .o_rdata (store_q)
  );

  // Port pins come from outside the clock domain: four flops each,
  // and a bit only changes once the second and third stages agree
  wire [23:0] pins_raw = {I_PORT_C_PINS, I_PORT_B_PINS, I_PORT_A_PINS};
  reg  [23:0] pin_s1;
  reg  [23:0] pin_s2;
  reg  [23:0] pin_s3;
  reg  [23:0] pin_q;
  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pin_s1 <= 24'h000000;
      pin_s2 <= 24'h000000;
      pin_s3 <= 24'h000000;
      pin_q  <= 24'h000000;
    end else begin
      pin_s1 <= pins_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q  <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 ^ pin_s3));
    end
  end

  // Special-register read mux, unimplemented bits forced to zero
  reg [7:0] sfr_rd;
  always @* begin
    case (eff_loc)
      `ADDR_INDIRECT:   sfr_rd = `READ_ZERO;
      `ADDR_TIMER:      sfr_rd = I_TIMER;
      `ADDR_PCL:        sfr_rd = I_PCL;
      `ADDR_FLAGS:      sfr_rd = I_FLAGS;
      `ADDR_POINTER:    sfr_rd = ptr_rd;
      `ADDR_PORT_A:     sfr_rd = pin_q[7:0] & `MASK_PORT_A;
      `ADDR_PORT_B:     sfr_rd = pin_q[15:8];
      `ADDR_PORT_C:     sfr_rd = pin_q[23:16];
      `ADDR_POWER:      sfr_rd = O_POWER;
      `ADDR_WAKE:       sfr_rd = O_WAKE;
      `ADDR_PC_HIGH_BUFFER:     sfr_rd = O_PC_HIGH_BUFFER;
      `ADDR_PULL_DOWN:  sfr_rd = O_PULL_DOWN;
      `ADDR_OPEN_DRAIN: sfr_rd = O_OPEN_DRAIN;
      `ADDR_PULL_HIGH:  sfr_rd = O_PULL_HIGH;
      `ADDR_INT_EN:     sfr_rd = O_INT_EN;
      `ADDR_INT_FLAG:   sfr_rd = O_INT_FLAG;
      default:          sfr_rd = `READ_ZERO;
    endcase
  end

  // Read pipeline: select between storage and special registers
  reg       rd_pend;
  reg       rd_gp;
  reg [7:0] sfr_hold;
  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rd_pend  <= 1'b0;
      rd_gp    <= 1'b0;
      sfr_hold <= 8'h00;
    end else begin
      rd_pend  <= I_RD;
      rd_gp    <= gp_hit;
      sfr_hold <= sfr_rd;
    end
  end

  // Registered read answer
  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RDATA    <= 8'h00;
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= rd_pend;
      if (rd_pend) begin
        O_RDATA <= rd_gp ? store_q : sfr_hold;
      end
    end
  end

  // Special-register writes; self-referencing indirect write is dropped
  wire sfr_wr = I_WR && !gp_hit && !self_ref;
  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ptr_loc      <= 6'h00;
      ptr_bank     <= 2'h0;
      O_PORT_A     <= 8'h00;
      O_PORT_B     <= 8'h00;
      O_PORT_C     <= 8'h00;
      O_POWER      <= 8'h00;
      O_WAKE       <= 8'h00;
      O_PC_HIGH_BUFFER     <= 8'h00;
      O_PULL_DOWN  <= 8'h00;
      O_OPEN_DRAIN <= 8'h00;
      O_PULL_HIGH  <= 8'h00;
      O_INT_EN     <= 8'h00;
      O_INT_FLAG   <= 8'h00;
    end else if (sfr_wr) begin
      case (eff_loc)
        `ADDR_POINTER: begin
          ptr_loc  <= I_WDATA[`PTR_LOC_MSB:0];
          ptr_bank <= FOUR_BANK ?
                      I_WDATA[`PTR_BANK_MSB:`PTR_BANK_LSB] : 2'h0;
        end
        `ADDR_PORT_A:     O_PORT_A     <= I_WDATA & `MASK_PORT_A;
        `ADDR_PORT_B:     O_PORT_B     <= I_WDATA;
        `ADDR_PORT_C:     O_PORT_C     <= I_WDATA;
        `ADDR_POWER:      O_POWER      <= I_WDATA & `MASK_POWER;
        `ADDR_WAKE:       O_WAKE       <= I_WDATA;
        `ADDR_PC_HIGH_BUFFER:     O_PC_HIGH_BUFFER     <= I_WDATA & pch_mask(VARIANT);
        `ADDR_PULL_DOWN:  O_PULL_DOWN  <= I_WDATA;
        `ADDR_OPEN_DRAIN: O_OPEN_DRAIN <= I_WDATA;
        `ADDR_PULL_HIGH:  O_PULL_HIGH  <= I_WDATA;
        `ADDR_INT_EN:     O_INT_EN     <= I_WDATA & `MASK_INT_EN;
        `ADDR_INT_FLAG:   O_INT_FLAG   <= I_WDATA & `MASK_INT_FLAG;
        default: ;
      endcase
    end
  end

  // Peripheral-owned writes (timer, PC low, flags) forwarded one cycle on
  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PERIPH_SEL  <= 6'h00;
      O_PERIPH_DATA <= 8'h00;
      O_PERIPH_WR   <= 1'b0;
      O_POINTER     <= 8'h00;
    end else begin
      O_PERIPH_WR   <= sfr_wr && ((eff_loc == `ADDR_TIMER) ||
                                  (eff_loc == `ADDR_PCL) ||
                                  (eff_loc == `ADDR_FLAGS));
      O_PERIPH_SEL  <= eff_loc;
      O_PERIPH_DATA <= I_WDATA;
      O_POINTER     <= ptr_rd;
    end
  end
endmodule // dmem_decode
`default_nettype wire

// [dmem_decode_props.sv]
/* Checker for the data memory decoder ports.
   Assumes a bind from the bench and a gap after pointer writes. */
`timescale 1ns/10ps
`default_nettype none
module dmem_decode_props #(
  parameter logic [1:0] VARIANT = 2'h3  // Memory-size variant
) (
  input wire logic       I_SYS_CLK,     // Clock
  input wire logic       I_RST_B,       // Reset
  input wire logic       I_RD,          // Read
  input wire logic       I_WR,          // Write
  input wire logic       I_INDIRECT,    // Indirect
  input wire logic [5:0] I_ADDR,        // Operand
  input wire logic [7:0] I_WDATA,       // Data in
  input wire logic [7:0] O_RDATA,       // Data out
  input wire logic       O_RD_VALID,    // Answer
  input wire logic [5:0] O_PERIPH_SEL,  // Peripheral loc
  input wire logic [7:0] O_PERIPH_DATA, // Peripheral data
  input wire logic       O_PERIPH_WR,   // Peripheral write
  input wire logic [7:0] O_POINTER,     // Pointer
  input wire logic [7:0] O_PORT_A,      // Port A latch
  input wire logic [7:0] O_PORT_B,      // Port B latch
  input wire logic [7:0] O_POWER,       // Power control
  input wire logic [7:0] O_PC_HIGH_BUFFER,      // PC high buffer
  input wire logic [7:0] O_INT_EN,      // Int enables
  input wire logic [7:0] O_INT_FLAG     // Int flags
);
  // Implemented PC high bits per variant
  localparam logic [7:0] PCH_MASK = (VARIANT == 2'h3) ? 8'h07 :
                                    (VARIANT == 2'h2) ? 8'h03 : 8'h01;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_B);
  AST_READ_LATENCY: assert property (I_RD |-> ##2 O_RD_VALID)
    else $error("read answer missing");
  AST_SELF_READ_ZERO: assert property (I_RD && I_INDIRECT &&
    O_POINTER[5:0] == 6'h00 |-> ##2 O_RDATA == 8'h00)
    else $error("self read not zero");
  AST_SELF_WRITE_NOP: assert property (I_WR && I_INDIRECT &&
    O_POINTER[5:0] == 6'h00 |=> !O_PERIPH_WR && $stable(O_PORT_B)
    && $stable(O_PC_HIGH_BUFFER) && $stable(O_INT_EN))
    else $error("self write changed state");
  AST_UNIMPL_ZERO: assert property (O_PORT_A[7:4] == 4'h0 &&
    O_POWER[3:0] == 4'h0 && O_INT_EN[6:4] == 3'h0 && O_INT_FLAG[7:3] == 5'h00)
    else $error("unimplemented bit set");
  AST_PCH_WIDTH: assert property ((O_PC_HIGH_BUFFER & ~PCH_MASK) == 8'h00)
    else $error("pc high buffer too wide");
  AST_POINTER_BANK: assert property (I_WR && !I_INDIRECT &&
    I_ADDR == 6'h04 |-> ##2 O_POINTER == $past(I_WDATA, 2))
    else $error("pointer not written");
  AST_PERIPH_FWD: assert property (I_WR && !I_INDIRECT &&
    I_ADDR inside {6'h01, 6'h02, 6'h03} |=> O_PERIPH_WR &&
    O_PERIPH_SEL == $past(I_ADDR) && O_PERIPH_DATA == $past(I_WDATA))
    else $error("peripheral write lost");
  AST_PORT_B_LATCH: assert property (I_WR && !I_INDIRECT &&
    I_ADDR == 6'h06 |=> O_PORT_B == $past(I_WDATA))
    else $error("port b latch wrong");
endmodule // dmem_decode_props
`default_nettype wire

// [dmem_cpu_model.sv]
/* CPU datapath model issuing one register access at a time.
   Assumes the decoder answers reads two edges after taking them. */
`timescale 1ns/10ps
`default_nettype none
module dmem_cpu_model (
  input  wire logic       i_clk,   // Core clock
  input  wire logic       i_valid, // Read answer
  input  wire logic [7:0] i_rdata, // Read data
  output var  logic       o_rd,    // Read strobe
  output var  logic       o_wr,    // Write strobe
  output var  logic       o_ind,   // Indirect select
  output var  logic [5:0] o_addr,  // Operand
  output var  logic [7:0] o_wdata  // Write data
);
  // Idle bus at time zero
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_ind = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
  end
  // Strobe held over one edge; then address and data are inverted, not kept
  task automatic access(input logic w, input logic ind, input logic [5:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic ok);
    @(posedge i_clk);
    #1;
    o_wr = w;
    o_rd = !w;
    o_ind = ind;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    ok = w;
    q = 8'h00;
    for (int n = 0; n < 3 && !ok; n++) begin
      @(posedge i_clk);
      #1;
      q = i_rdata;
      ok = i_valid;
    end
  endtask
endmodule // dmem_cpu_model
`default_nettype wire

// [dmem_decode_tb_top.sv]
/* Self-checking bench for the data memory decoder, four-bank variant.
   Assumes the CPU model and the port checker sit beside it. */
`timescale 1ns/10ps
`default_nettype none
module dmem_decode_tb_top;
  localparam logic [1:0] VARIANT = 2'h3;
  typedef struct {logic [5:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic       I_SYS_CLK, I_RST_B;
  logic [7:0] I_TIMER, I_PCL, I_FLAGS;
  logic [7:0] I_PORT_A_PINS, I_PORT_B_PINS, I_PORT_C_PINS;
  wire        I_RD, I_WR, I_INDIRECT, O_RD_VALID, O_PERIPH_WR;
  wire  [5:0] I_ADDR, O_PERIPH_SEL;
  wire  [7:0] I_WDATA, O_RDATA, O_PERIPH_DATA, O_POINTER, O_PORT_A;
  wire  [7:0] O_PORT_B, O_PORT_C, O_POWER, O_WAKE, O_PC_HIGH_BUFFER, O_PULL_DOWN;
  wire  [7:0] O_OPEN_DRAIN, O_PULL_HIGH, O_INT_EN, O_INT_FLAG;
  int         failures, checks_done;
  logic [7:0] q;
  logic       ok;
  row_t rows [11] = '{'{6'h08, 8'hff, 8'hf0}, '{6'h0a, 8'hff, 8'h07},
    '{6'h0e, 8'hff, 8'h8f}, '{6'h0f, 8'hff, 8'h07}, '{6'h0b, 8'ha5, 8'ha5},
    '{6'h05, 8'h00, 8'h0f}, '{6'h06, 8'h4b, 8'h96}, '{6'h07, 8'h00, 8'h3c},
    '{6'h01, 8'h77, 8'h5a}, '{6'h10, 8'h3c, 8'h3c}, '{6'h2f, 8'hc3, 8'hc3}};
  dmem_decode #(.VARIANT(VARIANT), .HAS_PORT_C_DATA(1)) u_dmem_decode (.*);
  dmem_cpu_model u_dmem_cpu_model (.i_clk(I_SYS_CLK), .i_valid(O_RD_VALID),
    .i_rdata(O_RDATA), .o_rd(I_RD), .o_wr(I_WR), .o_ind(I_INDIRECT),
    .o_addr(I_ADDR), .o_wdata(I_WDATA));
  // Verdict and end of run
  task automatic complete_run();
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare one byte
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic ind, input logic [5:0] a, input logic [7:0] d);
    u_dmem_cpu_model.access(1'b1, ind, a, d, q, ok);
  endtask
  // Read and compare; a missing answer ends the run
  task automatic rd_chk(input logic ind, input logic [5:0] a, input logic [7:0] e);
    u_dmem_cpu_model.access(1'b0, ind, a, 8'h00, q, ok);
    if (!ok) begin
      failures++;
      complete_run();
    end
    check($sformatf("loc %h", a), q, e);
  endtask
  // Free-running core clock
  initial begin
    I_SYS_CLK = 1'b0;
    forever #5 I_SYS_CLK = ~I_SYS_CLK;
  end
  // Main sequence
  initial begin
    I_RST_B = 1'b0;
    I_TIMER = 8'h5a;
    I_PCL = 8'h21;
    I_FLAGS = 8'h03;
    I_PORT_A_PINS = 8'hff;
    I_PORT_B_PINS = 8'h96;
    I_PORT_C_PINS = 8'h3c;
    repeat (16) @(posedge I_SYS_CLK);
    #1 I_RST_B = 1'b1;
    check("pointer", O_POINTER, 8'h00);
    foreach (rows[i]) begin
      wr(1'b0, rows[i].a, rows[i].d);
      rd_chk(1'b0, rows[i].a, rows[i].e);
    end
    for (int b = 0; b < 4; b++) begin
      wr(1'b0, 6'h04, {b[1:0], 6'h38});
      wr(1'b1, 6'h00, 8'h10 + b[7:0]);
    end
    for (int b = 0; b < 4; b++) begin
      wr(1'b0, 6'h04, {b[1:0], 6'h38});
      rd_chk(1'b1, 6'h00, 8'h10 + b[7:0]);
      rd_chk(1'b0, 6'h38, 8'h10 + b[7:0]);
    end
    // Shared location written from bank 2, read from bank 0
    wr(1'b0, 6'h04, 8'ha0);
    wr(1'b1, 6'h00, 8'h5e);
    wr(1'b0, 6'h04, 8'h20);
    rd_chk(1'b1, 6'h00, 8'h5e);
    // Pointer on the indirect location itself
    wr(1'b0, 6'h04, 8'h00);
    wr(1'b1, 6'h00, 8'h99);
    rd_chk(1'b1, 6'h00, 8'h00);
    rd_chk(1'b0, 6'h0b, 8'ha5);
    check("pointer", O_POINTER, 8'h00);
    // Indirect write reaching a port latch
    wr(1'b0, 6'h04, 8'h06);
    wr(1'b1, 6'h00, 8'h5a);
    check("port b", O_PORT_B, 8'h5a);
    // Reset in mid-run clears the latches at once
    I_RST_B = 1'b0;
    #1 check("port b", O_PORT_B, 8'h00);
    complete_run();
  end
endmodule // dmem_decode_tb_top
bind dmem_decode dmem_decode_props #(.VARIANT(VARIANT)) u_dmem_decode_props (.*);
`default_nettype wire
